// ===== verilog/plcp_tx_pkg.sv
package plcp_tx_pkg;
  // fixed frame values
  localparam logic [7:0] A1_VALUE = 8'hF6;
  localparam logic [7:0] A2_VALUE = 8'h28;
  localparam logic [7:0] TRAILER_FILL = 8'hCC;
  localparam logic [3:0] TOP_SUBFRAME = 4'h8;
  localparam logic [5:0] A2_COL = 6'h01;
  localparam logic [5:0] POI_COL = 6'h02;
  localparam logic [5:0] OH_COL = 6'h03;
  localparam logic [5:0] LAST_COL = 6'h38;
  localparam int CORE_BYTES = 513;
  localparam logic [9:0] PERIOD_RESET = 10'h214;
  localparam logic [4:0] TRAILER_MIN = 5'h11;
  localparam logic [4:0] TRAILER_MAX = 5'h15;
  localparam logic [4:0] TRAILER_RESET = 5'h13;
  // register offsets and reset values
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] GROWTH_OFFSET = 8'h04;
  localparam logic [7:0] MGMT_OFFSET = 8'h08;
  localparam logic [7:0] ERR_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0012;
  localparam logic [31:0] GROWTH_RESET = 32'h0000_0000;
  localparam logic [31:0] MGMT_RESET = 32'h0000_0000;
  localparam logic [31:0] ERR_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {UC_TRACE, UC_HDLC, UC_REG, UC_SPARE} uc_src_type;
  typedef enum logic [1:0] {FR_A1, FR_POI, FR_A1A2, FR_POI2} fr_pattern_type;
  typedef enum logic {ST_SUBFRAME, ST_TRAILER} frame_state_type;

  // transmit_control_reg layout
  typedef struct packed {
    logic [18:0] spare;
    logic [3:0] rei_reg;
    logic [2:0] link_status_signal;
    logic remote_alarm_indication;
    logic rei_auto;
    logic m1_hdlc;
    logic m2_hdlc;
    uc_src_type user_channel_source_select;
  } ctrl_type;

  // transmit_error_insert_reg layout
  typedef struct packed {
    logic [19:0] spare;
    logic rei_cont;
    logic rei_eight;
    logic rei_en;
    logic bip_cont;
    logic bip_byte;
    logic bip_en;
    fr_pattern_type fr_pattern;
    logic fr_byte;
    logic fr_en;
    logic manual_src;
    logic software_error_trigger;
  } err_type;

  // cycle/stuff code for a trailer length
  function automatic logic [7:0] c1_code(input logic [4:0] len);
    case (len)
      5'h11: return 8'h3B;
      5'h12: return 8'h4F;
      5'h13: return 8'h75;
      5'h14: return 8'h9D;
      default: return 8'hA7;
    endcase
  endfunction : c1_code
endpackage : plcp_tx_pkg

// ===== verilog/plcp_tx_e3.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module plcp_tx_e3 import plcp_tx_pkg::*; #(
  parameter int PHASE_TARGET = 0
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // framer side
  input wire logic byte_strobe_in,
  input wire logic e3_frame_start_in,
  input wire logic ref_8k_in,
  output logic [7:0] line_data_out,
  output logic line_valid_out,
  // cell payload
  input wire logic [7:0] pay_data_in,
  input wire logic pay_valid_in,
  output logic pay_take_out,
  // trace, hdlc and receive side
  input wire logic [7:0] trace_data_in,
  output logic trace_take_out,
  input wire logic [7:0] hdlc_data_in,
  output logic hdlc_take_out,
  input wire logic [7:0] rx_bip_err_in,
  input wire logic rx_bip_valid_in,
  // error and overhead pins
  input wire logic manual_error_input_in,
  input wire logic [7:0] tx_overhead_serial_bit_in,
  input wire logic [7:0] tx_overhead_bit_enable_in,
  output logic tx_overhead_port_clock_out,
  output logic tx_overhead_frame_start_out
);
  if (PHASE_TARGET < 0 || PHASE_TARGET > 1023) begin : g_bad_phase
    $error("PHASE_TARGET must lie in 0..1023");
  end

  ctrl_type ctrl_q;
  err_type err_q;
  logic [31:0] grow_q, mgmt_q;
  frame_state_type st_q;
  logic [3:0] sfn_q, rei_auto_q;
  logic [5:0] col_q;
  logic [4:0] tcnt_q, tlen_q;
  logic [9:0] cnt8k_q, period_q, fpos_q, phase_q;
  logic [7:0] b1_q, acc_q, oh_en_s1, oh_en_s2, oh_dat_s1, oh_dat_s2;
  logic ref_s1, ref_s2, ref_s3, man_s1, man_s2, man_s3;
  logic sw_trig_q, fr_pend_q, fr_second_q, bip_pend_q, rei_pend_q;
  logic [7:0] gen_b, err_b, out_b;
  logic tick, sub, oh, take_pay, take_tr, take_hd, trig;
  logic fr_hit, fr_first, bip_hit, rei_hit, acc_ph, wr;

  // odd-parity path overhead identifier for a sub-frame
  function automatic logic [7:0] poi_byte(input logic [3:0] n);
    return {2'b00, n, 1'b0, ~^n};
  endfunction : poi_byte

  function automatic logic [3:0] popcount(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {3'b000, v[i]};
    end
    return c;
  endfunction : popcount

  // trailer length from measured 8 kHz period and E3 frame phase
  function automatic logic [4:0] trailer_len(input logic [9:0] per, input logic [9:0] ph);
    int n;
    n = int'(per) - CORE_BYTES;
    if (int'(ph) > PHASE_TARGET) begin
      n = n + 1;
    end else if (int'(ph) < PHASE_TARGET) begin
      n = n - 1;
    end
    if (n < int'(TRAILER_MIN)) n = int'(TRAILER_MIN);
    if (n > int'(TRAILER_MAX)) n = int'(TRAILER_MAX);
    return n[4:0];
  endfunction : trailer_len

  assign tick = ce_in & byte_strobe_in;
  assign sub = (st_q == ST_SUBFRAME);
  assign oh = sub && (col_q == OH_COL);
  assign trig = err_q.manual_src ? (man_s2 & ~man_s3) : sw_trig_q;
  assign acc_ph = psel_in & penable_in;
  assign wr = acc_ph & pready_out & pwrite_in;

  // frame position: nine sub-frames of 57 bytes, then the trailer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ST_SUBFRAME;
      sfn_q <= TOP_SUBFRAME;
      col_q <= 6'h00;
      tcnt_q <= 5'h00;
    end else if (tick) begin
      case (st_q)
        ST_SUBFRAME: begin
          if (col_q == LAST_COL) begin
            col_q <= 6'h00;
            if (sfn_q == 4'h0) begin
              st_q <= ST_TRAILER;
              tcnt_q <= 5'h00;
            end else begin
              sfn_q <= sfn_q - 4'h1;
            end
          end else begin
            col_q <= col_q + 6'h01;
          end
        end
        ST_TRAILER: begin
          if (tcnt_q == tlen_q - 5'h01) begin
            st_q <= ST_SUBFRAME;
            sfn_q <= TOP_SUBFRAME;
          end else begin
            tcnt_q <= tcnt_q + 5'h01;
          end
        end
        default: st_q <= ST_SUBFRAME;
      endcase
    end
  end

  // input synchronisers for pins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {ref_s1, ref_s2, ref_s3, man_s1, man_s2, man_s3} <= 6'h00;
      {oh_en_s1, oh_en_s2, oh_dat_s1, oh_dat_s2} <= 32'h0000_0000;
    end else if (ce_in) begin
      {ref_s1, ref_s2, ref_s3} <= {ref_8k_in, ref_s1, ref_s2};
      {man_s1, man_s2, man_s3} <= {manual_error_input_in, man_s1, man_s2};
      {oh_en_s1, oh_en_s2} <= {tx_overhead_bit_enable_in, oh_en_s1};
      {oh_dat_s1, oh_dat_s2} <= {tx_overhead_serial_bit_in, oh_dat_s1};
    end
  end

  // 8 kHz period, E3 phase and trailer length choice
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt8k_q <= 10'h000;
      period_q <= PERIOD_RESET;
      fpos_q <= 10'h000;
      phase_q <= 10'h000;
      tlen_q <= TRAILER_RESET;
    end else if (ce_in) begin
      if (ref_s2 & ~ref_s3) begin
        period_q <= cnt8k_q;
        cnt8k_q <= 10'h000;
      end else if (byte_strobe_in) begin
        cnt8k_q <= cnt8k_q + 10'h001;
      end
      if (tick) begin
        fpos_q <= (st_q == ST_TRAILER && tcnt_q == tlen_q - 5'h01) ? 10'h000 : fpos_q + 10'h001;
      end
      if (e3_frame_start_in) begin
        phase_q <= fpos_q;
      end
      if (tick && sub && sfn_q == 4'h0 && col_q == 6'h00) begin
        tlen_q <= trailer_len(period_q, phase_q);
      end
    end
  end

  // generation, then error insertion, then external overhead
  always_comb begin
    gen_b = pay_valid_in ? pay_data_in : 8'h00;
    take_pay = sub && col_q > OH_COL;
    take_tr = 1'b0;
    take_hd = 1'b0;
    if (!sub) begin
      gen_b = TRAILER_FILL;
    end else if (col_q == 6'h00) begin
      gen_b = A1_VALUE;
    end else if (col_q == A2_COL) begin
      gen_b = A2_VALUE;
    end else if (col_q == POI_COL) begin
      gen_b = poi_byte(sfn_q);
    end else if (oh) begin
      case (sfn_q)
        4'h8: gen_b = grow_q[7:0];
        4'h7: gen_b = grow_q[15:8];
        4'h6: gen_b = grow_q[23:16];
        4'h5: begin
          case (ctrl_q.user_channel_source_select)
            UC_TRACE: begin
              gen_b = trace_data_in;
              take_tr = 1'b1;
            end
            UC_HDLC: begin
              gen_b = hdlc_data_in;
              take_hd = 1'b1;
            end
            default: gen_b = grow_q[31:24];
          endcase
        end
        4'h4: gen_b = b1_q;
        4'h3: begin
          gen_b[7:4] = ctrl_q.rei_auto ? rei_auto_q : ctrl_q.rei_reg;
          gen_b[3] = ctrl_q.remote_alarm_indication;
          gen_b[2:0] = ctrl_q.link_status_signal;
        end
        4'h2: begin
          gen_b = ctrl_q.m2_hdlc ? hdlc_data_in : mgmt_q[7:0];
          take_hd = ctrl_q.m2_hdlc;
        end
        4'h1: begin
          gen_b = ctrl_q.m1_hdlc ? hdlc_data_in : mgmt_q[15:8];
          take_hd = ctrl_q.m1_hdlc;
        end
        default: gen_b = c1_code(tlen_q);
      endcase
    end
    // framing error positions per pattern
    fr_first = 1'b0;
    fr_hit = 1'b0;
    if (sub) begin
      case (err_q.fr_pattern)
        FR_A1: fr_first = col_q == 6'h00;
        FR_POI: fr_first = col_q == POI_COL;
        FR_A1A2: begin
          fr_first = col_q == 6'h00;
          fr_hit = col_q == A2_COL && fr_second_q;
        end
        default: begin
          fr_first = col_q == POI_COL;
          fr_hit = col_q == POI_COL && fr_second_q;
        end
      endcase
    end
    fr_first = fr_first & fr_pend_q;
    fr_hit = fr_hit | fr_first;
    bip_hit = oh && sfn_q == 4'h4 && (bip_pend_q || (err_q.bip_en && err_q.bip_cont));
    rei_hit = oh && sfn_q == 4'h3 && (rei_pend_q || (err_q.rei_en && err_q.rei_cont));
    err_b = gen_b;
    if (fr_hit) begin
      err_b = err_b ^ (err_q.fr_byte ? 8'hFF : 8'h01);
    end
    if (bip_hit) begin
      err_b = err_b ^ (err_q.bip_byte ? 8'hFF : 8'h01);
    end
    if (rei_hit) begin
      err_b[7:4] = err_q.rei_eight ? 4'h8 : 4'h1;
    end
    out_b = err_b;
    if (oh && (sfn_q == 4'h4 || sfn_q == 4'h0)) begin
      out_b = err_b ^ (oh_dat_s2 & oh_en_s2);
    end else if (oh) begin
      out_b = (err_b & ~oh_en_s2) | (oh_dat_s2 & oh_en_s2);
    end
  end

  // output byte and hand-shake pulses
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      line_data_out <= 8'h00;
      {line_valid_out, pay_take_out, trace_take_out, hdlc_take_out} <= 4'h0;
      {tx_overhead_port_clock_out, tx_overhead_frame_start_out} <= 2'b00;
    end else if (ce_in) begin
      line_valid_out <= byte_strobe_in;
      pay_take_out <= tick & take_pay & pay_valid_in;
      trace_take_out <= tick & take_tr;
      hdlc_take_out <= tick & take_hd;
      tx_overhead_port_clock_out <= tick & oh;
      tx_overhead_frame_start_out <= tick & oh & (sfn_q == TOP_SUBFRAME);
      if (byte_strobe_in) begin
        line_data_out <= out_b;
      end
    end
  end

  // parity over the finished frame, trailer excluded
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q <= 8'h00;
      b1_q <= 8'h00;
    end else if (tick && sub) begin
      if (sfn_q == 4'h0 && col_q == LAST_COL) begin
        b1_q <= acc_q ^ out_b;
        acc_q <= 8'h00;
      end else begin
        acc_q <= acc_q ^ out_b;
      end
    end
  end

  // automatic remote error count from the receive side
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rei_auto_q <= 4'h0;
    end else if (ce_in && rx_bip_valid_in) begin
      rei_auto_q <= popcount(rx_bip_err_in);
    end
  end

  // single-shot requests; a new trigger wins over the clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {fr_pend_q, fr_second_q, bip_pend_q, rei_pend_q} <= 4'h0;
    end else if (ce_in) begin
      if (tick && fr_first) fr_pend_q <= 1'b0;
      if (tick && bip_hit) bip_pend_q <= 1'b0;
      if (tick && rei_hit) rei_pend_q <= 1'b0;
      if (tick && fr_hit) begin
        fr_second_q <= fr_first && err_q.fr_pattern inside {FR_A1A2, FR_POI2};
      end
      if (trig && err_q.fr_en) fr_pend_q <= 1'b1;
      if (trig && err_q.bip_en) bip_pend_q <= 1'b1;
      if (trig && err_q.rei_en) rei_pend_q <= 1'b1;
    end
  end

  // apb slave: one wait state, write lands on the ready edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      pready_out <= acc_ph & ~pready_out;
      if (acc_ph & ~pready_out) begin
        pslverr_out <= 1'b0;
        case (paddr_in)
          CTRL_OFFSET: prdata_out <= ctrl_q;
          GROWTH_OFFSET: prdata_out <= grow_q;
          MGMT_OFFSET: prdata_out <= mgmt_q;
          ERR_OFFSET: prdata_out <= err_q;
          STATUS_OFFSET: prdata_out <= {7'h00, rei_auto_q, fr_pend_q, bip_pend_q,
                                        rei_pend_q, tlen_q, b1_q, !sub, sfn_q};
          default: begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // register writes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_RESET;
      grow_q <= GROWTH_RESET;
      mgmt_q <= MGMT_RESET;
      err_q <= ERR_RESET;
      sw_trig_q <= 1'b0;
    end else if (ce_in) begin
      sw_trig_q <= wr && paddr_in == ERR_OFFSET && pwdata_in[0];
      if (wr) begin
        case (paddr_in)
          CTRL_OFFSET: ctrl_q <= {19'h00000, pwdata_in[12:0]};
          GROWTH_OFFSET: grow_q <= pwdata_in;
          MGMT_OFFSET: mgmt_q <= {16'h0000, pwdata_in[15:0]};
          ERR_OFFSET: err_q <= {20'h00000, pwdata_in[11:1], 1'b0};
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_align_byte: assert property (
    tick && sub && col_q == 6'h00 && !fr_hit |=> line_data_out == A1_VALUE)
    else $error("alignment byte wrong");
  chk_poi_byte: assert property (
    tick && sub && col_q == POI_COL && !fr_hit |=> line_data_out == poi_byte($past(sfn_q)))
    else $error("identifier byte wrong");
  chk_trailer_start: assert property (
    tick && sub && sfn_q == 4'h0 && col_q == LAST_COL |=> st_q == ST_TRAILER && tcnt_q == 5'h00)
    else $error("trailer did not follow sub-frame 0");
  chk_trailer_range: assert property (
    tlen_q >= TRAILER_MIN && tlen_q <= TRAILER_MAX)
    else $error("trailer length out of range");
  chk_trailer_end: assert property (
    tick && !sub && tcnt_q == tlen_q - 5'h01 |=> sub && sfn_q == TOP_SUBFRAME && col_q == 6'h00)
    else $error("trailer length not kept");
  chk_trailer_fill: assert property (
    tick && !sub |=> line_data_out == TRAILER_FILL)
    else $error("trailer fill wrong");
  chk_c1_code: assert property (
    tick && oh && sfn_q == 4'h0 && oh_en_s2 == 8'h00 |=> line_data_out == c1_code($past(tlen_q)))
    else $error("cycle/stuff byte wrong");
  chk_rei_force: assert property (
    tick && rei_hit && oh_en_s2[7:4] == 4'h0
    |=> line_data_out[7:4] == ($past(err_q.rei_eight) ? 4'h8 : 4'h1))
    else $error("remote error not forced");
  chk_oh_replace: assert property (
    tick && oh && sfn_q != 4'h4 && sfn_q != 4'h0
    |=> ((line_data_out ^ $past(oh_dat_s2)) & $past(oh_en_s2)) == 8'h00)
    else $error("external overhead bit not inserted");
  chk_single_shot: assert property (
    tick && rei_hit && rei_pend_q && !trig |=> !rei_pend_q)
    else $error("single-shot request not consumed");
  chk_apb_wait: assert property (
    ce_in && acc_ph && !pready_out |=> pready_out)
    else $error("apb answer late");

  cov_trailer: cover property (tick && !sub && tcnt_q == tlen_q - 5'h01);
  cov_bip_err: cover property (tick && bip_hit && !err_q.bip_cont);
  cov_fr_pair: cover property (tick && fr_hit && fr_second_q);
endmodule : plcp_tx_e3

// ===== bench/plcp_far_model.sv
`timescale 1ns/10ps
module plcp_far_model (
  // clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  // payload handshake
  input wire logic pay_take_in,
  output logic [7:0] pay_data_out,
  output logic pay_valid_out,
  output logic [7:0] aux_data_out,
  // framer timing
  output logic byte_strobe_out,
  output logic e3_frame_start_out,
  output logic ref_8k_out
);
  logic [10:0] tick_q;
  logic [6:0] cell_q;

  // strobe every second cycle; 8 kHz reference and e3 frame mark every 1250 cycles
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_q <= 11'h000;
      byte_strobe_out <= 1'b0;
      ref_8k_out <= 1'b0;
      e3_frame_start_out <= 1'b0;
    end else if (go_in) begin
      tick_q <= (tick_q == 11'h4E1) ? 11'h000 : tick_q + 11'h001;
      byte_strobe_out <= ~byte_strobe_out;
      ref_8k_out <= (tick_q < 11'h271);
      e3_frame_start_out <= (tick_q == 11'h100);
    end
  end

  // upstream steps to the next cell byte on each take pulse
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cell_q <= 7'h00;
    end else if (pay_take_in) begin
      cell_q <= cell_q + 7'h01;
    end
  end

  // cell bytes stay below 80h so they never look like fill or the A1 byte
  assign pay_data_out = {1'b0, cell_q};
  assign pay_valid_out = go_in;
  assign aux_data_out = {1'b1, cell_q};
endmodule : plcp_far_model

// ===== bench/tb_tx_e3_plcp_frame_processor.sv
`timescale 1ns/10ps
module tb_tx_e3_plcp_frame_processor import plcp_tx_pkg::*;;
  logic clk_in, rst_in, psel, penable, pwrite, go, pready, pslverr, re;
  logic strobe, e3fs, ref8k, pvalid, ptake, lvalid, rxv, man;
  logic [7:0] paddr, pdata, aux, ldata, ov_d, ov_en, rxe;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] q[$];
  int n_fail, comparisons, cyc;
  int nerr[3];

  plcp_tx_e3 dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .byte_strobe_in(strobe), .e3_frame_start_in(e3fs), .ref_8k_in(ref8k),
    .line_data_out(ldata), .line_valid_out(lvalid), .pay_data_in(pdata),
    .pay_valid_in(pvalid), .pay_take_out(ptake), .trace_data_in(aux),
    .trace_take_out(), .hdlc_data_in(aux), .hdlc_take_out(), .rx_bip_err_in(rxe),
    .rx_bip_valid_in(rxv), .manual_error_input_in(man),
    .tx_overhead_serial_bit_in(ov_d), .tx_overhead_bit_enable_in(ov_en),
    .tx_overhead_port_clock_out(), .tx_overhead_frame_start_out());

  plcp_far_model far_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
    .pay_take_in(ptake), .pay_data_out(pdata), .pay_valid_out(pvalid),
    .aux_data_out(aux), .byte_strobe_out(strobe), .e3_frame_start_out(e3fs),
    .ref_8k_out(ref8k));

  // clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // output byte capture and hang guard
  always @(posedge clk_in) begin
    if (lvalid === 1'b1) q.push_back(ldata);
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // accepts the injected form on every match and counts it per class
  task automatic chk_alt(input logic [7:0] got, input logic [7:0] exp,
      input logic [7:0] alt, input int k);
    if (got === alt) begin
      nerr[k]++;
      comparisons++;
    end else check({24'h0, got}, {24'h0, exp});
  endtask : chk_alt

  // one apb transfer: setup, access held until pready is seen
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] path_overhead_identifier(input logic [3:0] s);
    logic [7:0] v;
    v = {2'b00, s, 2'b00};
    return v | {7'h00, ~^v};
  endfunction : path_overhead_identifier

  // external port: low nibble enabled, xor on parity and cycle/stuff bytes
  function automatic logic [7:0] ovh(input logic [7:0] g, input int s);
    return (s == 4 || s == 0) ? g ^ 8'h05 : (g & 8'hF0) | 8'h05;
  endfunction : ovh

  function automatic logic [7:0] c1(input int n);
    case (n)
      17: return 8'h3B;
      18: return 8'h4F;
      19: return 8'h75;
      20: return 8'h9D;
      default: return 8'hA7;
    endcase
  endfunction : c1

  task finish_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    int p, n, b;
    logic [7:0] par, b1;
    logic [6:0] cnt;
    logic [7:0] ext[9];
    ext = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h55, 8'h66, 8'h00};
    {psel, penable, pwrite, go, rxv, man} = 6'h00;
    {paddr, ov_d, ov_en, rxe, pwdata} = 64'h0;
    rst_in = 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    ov_d <= 8'h05;
    ov_en <= 8'h0F;
    apb(CTRL_OFFSET, 1'b0, 32'h0);
    check(rd, CTRL_RESET);
    apb(8'h20, 1'b0, 32'h0);
    check({31'h0, re}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(GROWTH_OFFSET, 1'b1, 32'h4433_2211);
    apb(MGMT_OFFSET, 1'b1, 32'h0000_6655);
    apb(CTRL_OFFSET, 1'b1, 32'h0000_0762);
    apb(ERR_OFFSET, 1'b1, 32'h0000_06CD);
    apb(ERR_OFFSET, 1'b1, 32'h0000_06CD);
    check(rd, 32'h0000_06CC);
    apb(ERR_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h0000_06CC);
    apb(GROWTH_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h4433_2211);
    go <= 1'b1;
    while (q.size() < 1700) @(posedge clk_in);
    p = 0;
    b1 = 8'h00;
    cnt = 7'h00;
    for (int f = 0; f < 3; f++) begin
      par = 8'h00;
      for (int s = 8; s >= 0; s--) begin
        b = p + (8 - s) * 57;
        chk_alt(q[b], A1_VALUE, ~A1_VALUE, 0);
        check(q[b+1], A2_VALUE);
        check(q[b+2], path_overhead_identifier(s[3:0]));
        if (s == 4) chk_alt(q[b+3], ovh(b1, 4), ovh(~b1, 4), 1);
        else if (s == 3) chk_alt(q[b+3], ovh(8'h3D, 3), ovh(8'h8D, 3), 2);
        else if (s != 0) check(q[b+3], ovh(ext[8-s], s));
        for (int i = 4; i < 57; i++) begin
          check(q[b+i], {1'b0, cnt});
          cnt = cnt + 7'h01;
        end
        for (int i = 0; i < 57; i++) par = par ^ q[b+i];
      end
      n = 0;
      while (q[p+513+n] === TRAILER_FILL) n++;
      check(n >= 17 && n <= 21, 1);
      check(q[p+459] ^ 8'h05, c1(n));
      p = p + 513 + n;
      b1 = par;
    end
    check(nerr[0], 1);
    check(nerr[1], 1);
    check(nerr[2], 1);
    // stop the stream, then receive parity mismatches and a manual trigger
    go <= 1'b0;
    apb(ERR_OFFSET, 1'b1, 32'h0000_0006);
    rxe <= 8'h0B;
    rxv <= 1'b1;
    man <= 1'b1;
    @(posedge clk_in);
    rxv <= 1'b0;
    repeat (4) @(posedge clk_in);
    man <= 1'b0;
    apb(STATUS_OFFSET, 1'b0, 32'h0);
    check({28'h0, rd[24:21]}, 32'h0000_0003);
    check({31'h0, rd[20]}, 32'h0000_0001);
    finish_test();
  end
endmodule : tb_tx_e3_plcp_frame_processor
